// File: logic/dps_pkg.sv
// package: timing constants and state encoding for the dual-port sram port controller
package dps_pkg;
   // ****************************************
   // widths
   // ****************************************
   localparam int ADDR_W = 10;
   localparam int DATA_W = 8;
   localparam int CLK_PERIOD_NS = 10;
   localparam int CNT_W = 6;
   // ****************************************
   // device timing, slowest grade (ns)
   // ****************************************
   localparam int WRITE_PULSE_NS = 55;
   localparam int WRITE_FLOAT_NS = 40;
   localparam int DATA_VALID_BEFORE_WRITE_END_NS = 40;
   localparam int ADDR_VALID_TO_WRITE_END_NS = 90;
   localparam int SELECT_TO_WRITE_END_NS = 90;
   localparam int WRITE_CYCLE_NS = 100;
   localparam int READ_CYCLE_NS = 100;
   localparam int READ_ACCESS_NS = 100;
   localparam int FLAG_ACCESS_NS = 50;
   // ****************************************
   // derived cycle counts (least times round up)
   // ****************************************
   localparam int WRITE_FLOAT_CYC = (WRITE_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DATA_VALID_CYC =
      (DATA_VALID_BEFORE_WRITE_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_BASE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_OE_CYC = WRITE_FLOAT_CYC + DATA_VALID_CYC;
   localparam int SELECT_CYC = (SELECT_TO_WRITE_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WRITE_CYC = (WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FLAG_CYC = (FLAG_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RECOVER_CYC = 1;

   typedef enum logic [5:0] {
      ST_IDLE   = 6'h01,
      ST_SETUP  = 6'h02,
      ST_FLAG   = 6'h04,
      ST_STROBE = 6'h08,
      ST_READ   = 6'h10,
      ST_RECOV  = 6'h20
   } dps_state_type;
endpackage : dps_pkg

// File: logic/dps_port_ctrl.sv
// module: host-side cycle generator for one asynchronous port of a dual-port sram
`timescale 1ns/1ps

// Functional notes
// - address changes only with strobe or select high
// - strobe width covers float plus data valid
// - expansion mode delays strobe by flag access
// - no host data drive while device drives
// - recovery counted from first rising enable
// - read: strobe high, enable low, address early
// - address valid 90 ns before write end
// - write data valid 40 ns before write end
// - select low 90 ns before write end
module dps_port_ctrl
#(
   parameter bit EXPANSION = 1'b0,
   parameter bit OE_IN_WRITE = 1'b0
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // user request
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic [dps_pkg::ADDR_W-1:0] reqAddr,
   input wire logic [dps_pkg::DATA_W-1:0] reqData,
   output logic reqReady,
   output logic rspValid,
   output logic [dps_pkg::DATA_W-1:0] rspData,
   // sram port pins
   output logic [dps_pkg::ADDR_W-1:0] memAddr,
   output logic memSelectN,
   output logic memWriteN,
   output logic memOutEnN,
   output logic [dps_pkg::DATA_W-1:0] memDataOut,
   output logic memDataOe,
   input wire logic [dps_pkg::DATA_W-1:0] memDataIn
);
   import dps_pkg::*;

   localparam int STROBE_CYC = (OE_IN_WRITE && PULSE_OE_CYC > PULSE_BASE_CYC) ?
      PULSE_OE_CYC : PULSE_BASE_CYC;
   localparam int STROBE_TOTAL = (STROBE_CYC > SELECT_CYC) ? STROBE_CYC : SELECT_CYC;
   localparam int FLAG_WAIT = EXPANSION ? FLAG_CYC : 0;
   localparam int WRITE_BODY = FLAG_WAIT + STROBE_TOTAL;
   localparam int WRITE_PAD = (WRITE_CYC > WRITE_BODY) ? WRITE_CYC - WRITE_BODY : RECOVER_CYC;
   // one shared low time for select and strobe: it must meet the pulse width,
   // the select-to-end time and, with the enable low, float plus data valid
   // expansion puts the flag wait between select and strobe; the cycle pad
   // only ever adds cycles, never removes the one recovery cycle

   typedef struct packed {
      dps_state_type state;
      logic [CNT_W-1:0] cnt;
      logic isWrite;
      logic reqReady;
      logic rspValid;
      logic [DATA_W-1:0] rspData;
      logic [ADDR_W-1:0] memAddr;
      logic memSelectN;
      logic memWriteN;
      logic memOutEnN;
      logic [DATA_W-1:0] memDataOut;
      logic memDataOe;
      logic [DATA_W-1:0] sync1;
      logic [DATA_W-1:0] sync2;
   } dps_regs_type;

   dps_regs_type st_reg;
   dps_regs_type st_next;

   // ****************************************
   // next state
   // ****************************************
   always_comb
   begin
      st_next = st_reg;
      // response is a one-cycle pulse; rspData holds until the next read
      st_next.rspValid = 1'b0;
      // pin data is asynchronous: two flops before anything reads it
      st_next.sync1 = memDataIn;
      st_next.sync2 = st_reg.sync1;
      case (st_reg.state)
         ST_IDLE:
         begin
            if (reqValid && st_reg.reqReady)
            begin
               // address moves only while select and strobe are high
               st_next.memAddr = reqAddr;
               st_next.isWrite = reqWrite;
               st_next.memDataOut = reqData;
               st_next.reqReady = 1'b0;
               st_next.state = ST_SETUP;
            end
         end
         ST_SETUP:
         begin
            if (st_reg.isWrite)
            begin
               // select falls with the strobe, or FLAG_WAIT cycles before it in expansion; enable low only with OE_IN_WRITE
               st_next.memOutEnN = OE_IN_WRITE ? 1'b0 : 1'b1;
               st_next.memSelectN = 1'b0;
               st_next.cnt = CNT_W'(FLAG_WAIT);
               st_next.state = EXPANSION ? ST_FLAG : ST_STROBE;
               if (!EXPANSION)
               begin
                  st_next.memWriteN = 1'b0;
                  st_next.cnt = CNT_W'(STROBE_TOTAL - 1);
               end
            end
            else
            begin
               // read: strobe high, enable low, address already stable
               st_next.memWriteN = 1'b1;
               st_next.memOutEnN = 1'b0;
               st_next.memSelectN = 1'b0;
               st_next.cnt = CNT_W'(READ_CYC + 2);
               st_next.state = ST_READ;
            end
         end
         ST_FLAG:
         begin
            // expansion: strobe only after flag access delay
            if (st_reg.cnt <= CNT_W'(1))
            begin
               st_next.memWriteN = 1'b0;
               st_next.cnt = CNT_W'(STROBE_TOTAL - 1);
               st_next.state = ST_STROBE;
            end
            else
               st_next.cnt = st_reg.cnt - CNT_W'(1);
         end
         ST_STROBE:
         begin
            // count runs down from STROBE_TOTAL-1, so the float wait starts at
            // the strobe fall and data then stands longer than data valid
            // drive data only once device outputs floated
            if (!OE_IN_WRITE || st_reg.cnt <= CNT_W'(STROBE_TOTAL - WRITE_FLOAT_CYC))
               st_next.memDataOe = 1'b1;
            if (st_reg.cnt == '0)
            begin
               // overlap ends: device latches the byte
               st_next.memWriteN = 1'b1;
               st_next.memSelectN = 1'b1;
               st_next.cnt = CNT_W'(WRITE_PAD);
               st_next.state = ST_RECOV;
            end
            else
               st_next.cnt = st_reg.cnt - CNT_W'(1);
         end
         ST_READ:
         begin
            // extra two cycles absorb the input synchroniser
            if (st_reg.cnt == '0)
            begin
               st_next.rspData = st_reg.sync2;
               st_next.rspValid = 1'b1;
               // select and enable rise together and float the device
               st_next.memSelectN = 1'b1;
               st_next.memOutEnN = 1'b1;
               st_next.cnt = CNT_W'(RECOVER_CYC);
               st_next.state = ST_RECOV;
            end
            else
               st_next.cnt = st_reg.cnt - CNT_W'(1);
         end
         ST_RECOV:
         begin
            // data held past the strobe rise; recovery from first rising enable
            st_next.memDataOe = 1'b0;
            st_next.memOutEnN = 1'b1;
            if (st_reg.cnt <= CNT_W'(1))
            begin
               st_next.reqReady = 1'b1;
               st_next.state = ST_IDLE;
            end
            else
               st_next.cnt = st_reg.cnt - CNT_W'(1);
         end
         default:
         begin
            st_next.state = ST_IDLE;
         end
      endcase
   end

   // ****************************************
   // registers
   // ****************************************
   // reset loads constants only; every strobe idles inactive high
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_reg <= '{state: ST_IDLE, cnt: '0, isWrite: 1'b0, reqReady: 1'b1,
            rspValid: 1'b0, rspData: '0, memAddr: '0, memSelectN: 1'b1,
            memWriteN: 1'b1, memOutEnN: 1'b1, memDataOut: '0, memDataOe: 1'b0,
            sync1: '0, sync2: '0};
      end
      else
         st_reg <= st_next;
   end

   assign reqReady = st_reg.reqReady;
   assign rspValid = st_reg.rspValid;
   assign rspData = st_reg.rspData;
   assign memAddr = st_reg.memAddr;
   assign memSelectN = st_reg.memSelectN;
   assign memWriteN = st_reg.memWriteN;
   assign memOutEnN = st_reg.memOutEnN;
   assign memDataOut = st_reg.memDataOut;
   assign memDataOe = st_reg.memDataOe;
endmodule : dps_port_ctrl

// File: bench/dps_port_ctrl_monitor.sv
// checker: pin-order assertions for the sram port controller
`timescale 1ns/1ps
module dps_port_ctrl_monitor (
   // clock, reset, user side
   input wire logic clk,
   input wire logic rst,
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic reqReady,
   input wire logic rspValid,
   // sram pins
   input wire logic [dps_pkg::ADDR_W-1:0] memAddr,
   input wire logic memSelectN,
   input wire logic memWriteN,
   input wire logic memOutEnN,
   input wire logic [dps_pkg::DATA_W-1:0] memDataOut,
   input wire logic memDataOe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_writeStart; $fell(memWriteN) ##0 !memSelectN; endsequence
   sequence s_readTake; reqValid && reqReady && !reqWrite; endsequence
   property p_addrHold; (!memSelectN && !memWriteN) |-> $stable(memAddr); endproperty
   a_addrHold: assert property (p_addrHold) else $error("address moved in write");
   property p_pulse; s_writeStart |-> (!memSelectN && !memWriteN)[*8] ##1 !memSelectN; endproperty
   a_pulse: assert property (p_pulse) else $error("write pulse short");
   property p_dataSetup; $rose(memWriteN) |-> $past(memDataOe, 4) && $stable(memDataOut) && memDataOe;
   endproperty
   a_dataSetup: assert property (p_dataSetup) else $error("write data late");
   property p_addrSetup; $rose(memWriteN) |-> $past(memAddr, 9) == memAddr; endproperty
   a_addrSetup: assert property (p_addrSetup) else $error("address late");
   property p_noClash;
      (memDataOe && !memOutEnN && !memSelectN) |-> (!memWriteN && $past(!memWriteN, 4));
   endproperty
   a_noClash: assert property (p_noClash) else $error("host drives into device");
   property p_flagWait;
      ($fell(memWriteN) && $past(!memSelectN)) |-> $past(!memSelectN, 5);
   endproperty
   a_flagWait: assert property (p_flagWait) else $error("strobe before flag delay");
   property p_recover; $rose(memWriteN) |-> memSelectN ##1 (!memDataOe && reqReady); endproperty
   a_recover: assert property (p_recover) else $error("write end order");
   property p_readHold;
      s_readTake |-> ##1 !reqReady ##1 (!memSelectN && !memOutEnN && memWriteN)[*8];
   endproperty
   a_readHold: assert property (p_readHold) else $error("read strobes wrong");
   property p_readEnd; s_readTake |-> ##[13:15] (rspValid && memSelectN && memOutEnN); endproperty
   a_readEnd: assert property (p_readEnd) else $error("read answer late");
endmodule : dps_port_ctrl_monitor
bind dps_port_ctrl dps_port_ctrl_monitor mon_u (.clk(clk), .rst(rst), .reqValid(reqValid),
   .reqWrite(reqWrite), .reqReady(reqReady), .rspValid(rspValid), .memAddr(memAddr),
   .memSelectN(memSelectN), .memWriteN(memWriteN), .memOutEnN(memOutEnN),
   .memDataOut(memDataOut), .memDataOe(memDataOe));

// File: bench/dps_sram_model.sv
// partner: behavioural 1k x 8 asynchronous sram port
`timescale 1ns/1ps
module dps_sram_model #(parameter int ACC_CYC = dps_pkg::READ_CYC) (
   input wire logic clk,
   input wire logic [9:0] addr,
   input wire logic selN,
   input wire logic weN,
   input wire logic oeN,
   input wire logic [7:0] bus,
   output logic [7:0] pinData
);
   logic [7:0] mem [0:1023];
   logic [7:0] last = 8'h00;
   logic ovl = 1'b0;
   int cnt = 0;
   wire drive = !selN && !oeN && weN;
   initial for (int i = 0; i < 1024; i++) mem[i] = 8'h00;
   // not yet valid: show a changing pattern, never a stale byte
   assign pinData = (drive && cnt >= ACC_CYC) ? mem[addr] : ~last;
   always @(posedge clk)
   begin
      cnt <= drive ? cnt + 1 : 0;
      last <= pinData;
      ovl <= !selN && !weN;
      if (ovl && (selN || weN)) mem[addr] <= bus;
   end
endmodule : dps_sram_model

// File: bench/dps_port_ctrl_tb.sv
// testbench: write and read cycles against the sram model
`timescale 1ns/1ps
module dps_port_ctrl_tb;
   import dps_pkg::*;
   logic clk = 1'b0, rst = 1'b1, reqValid = 1'b0, reqWrite = 1'b0;
   logic [ADDR_W-1:0] reqAddr = '0, memAddr;
   logic [DATA_W-1:0] reqData = '0, rspData, memDataOut, pinData, q;
   logic reqReady, rspValid, memSelectN, memWriteN, memOutEnN, memDataOe;
   wire [DATA_W-1:0] memDataIn = memDataOe ? memDataOut : pinData;
   logic useX = 1'b0;
   logic [ADDR_W-1:0] memAddrX;
   logic [DATA_W-1:0] rspDataX, memDataOutX, pinDataX;
   logic reqReadyX, rspValidX, memSelectNX, memWriteNX, memOutEnNX, memDataOeX;
   wire [DATA_W-1:0] memDataInX = memDataOeX ? memDataOutX : pinDataX;
   wire vldU = reqValid && !useX;
   wire vldX = reqValid && useX;
   int bad_count = 0, checks = 0, cyc = 0;
   always #5 clk = ~clk;
   dps_port_ctrl dut_u (.clk(clk), .rst(rst), .reqValid(vldU), .reqWrite(reqWrite),
      .reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid),
      .rspData(rspData), .memAddr(memAddr), .memSelectN(memSelectN), .memWriteN(memWriteN),
      .memOutEnN(memOutEnN), .memDataOut(memDataOut), .memDataOe(memDataOe),
      .memDataIn(memDataIn));
   dps_sram_model sram_u (.clk(clk), .addr(memAddr), .selN(memSelectN), .weN(memWriteN),
      .oeN(memOutEnN), .bus(memDataIn), .pinData(pinData));
   // second build: expansion wait and enable low through writes
   dps_port_ctrl #(.EXPANSION(1'b1), .OE_IN_WRITE(1'b1)) dut_x (.clk(clk), .rst(rst),
      .reqValid(vldX), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData),
      .reqReady(reqReadyX), .rspValid(rspValidX), .rspData(rspDataX), .memAddr(memAddrX),
      .memSelectN(memSelectNX), .memWriteN(memWriteNX), .memOutEnN(memOutEnNX),
      .memDataOut(memDataOutX), .memDataOe(memDataOeX), .memDataIn(memDataInX));
   dps_sram_model sramx_u (.clk(clk), .addr(memAddrX), .selN(memSelectNX), .weN(memWriteNX),
      .oeN(memOutEnNX), .bus(memDataInX), .pinData(pinDataX));
   task automatic expect8(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : expect8
   // one request, held until an edge sees ready high; a read then waits on its answer
   task automatic do_op(input logic w, input logic [9:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      q = 8'hEE;
      reqValid <= 1'b1;
      reqWrite <= w;
      reqAddr <= a;
      reqData <= d;
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while ((useX ? reqReadyX : reqReady) !== 1'b1 && n < 50);
      if ((useX ? reqReadyX : reqReady) !== 1'b1)
      begin
         bad_count++;
         $display("BAD %0t ready never came", $time);
      end
      // ready stands until the next edge, which takes the request
      @(posedge clk);
      reqValid <= 1'b0;
      if (!w)
      begin
         n = 0;
         do
         begin
            @(negedge clk);
            n++;
         end
         while ((useX ? rspValidX : rspValid) !== 1'b1 && n < 30);
         q = useX ? rspDataX : rspData;
         checks++;
         if ((useX ? rspValidX : rspValid) !== 1'b1 || n != READ_CYC + 5)
         begin
            bad_count++;
            $display("BAD %0t read answer after %0d cycles", $time, n);
         end
      end
   endtask : do_op
   // boundary addresses, back to back, then an overwrite
   task automatic t_walls();
      logic [9:0] a [4] = '{10'h000, 10'h3FF, 10'h155, 10'h2AA};
      logic [7:0] d [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h01};
      for (int i = 0; i < 4; i++) do_op(1'b1, a[i], d[i]);
      for (int i = 0; i < 4; i++)
      begin
         do_op(1'b0, a[i], 8'h00);
         expect8(q, d[i]);
      end
      do_op(1'b1, 10'h3FF, 8'h3C);
      do_op(1'b0, 10'h3FF, 8'h00);
      expect8(q, 8'h3C);
   endtask : t_walls
   // a request made while busy must be ignored
   task automatic t_refused();
      do_op(1'b1, 10'h010, 8'h77);
      @(posedge clk);
      reqValid <= 1'b1;
      reqAddr <= 10'h0F0;
      reqData <= 8'h99;
      repeat (3) @(posedge clk);
      reqValid <= 1'b0;
      do_op(1'b0, 10'h0F0, 8'h00);
      expect8(q, 8'h00);
      do_op(1'b0, 10'h010, 8'h00);
      expect8(q, 8'h77);
   endtask : t_refused
   // expansion flag wait and enable held low through the write
   task automatic t_modes();
      @(posedge clk);
      useX <= 1'b1;
      do_op(1'b1, 10'h2C3, 8'hC3);
      do_op(1'b1, 10'h13C, 8'h3C);
      do_op(1'b0, 10'h2C3, 8'h00);
      expect8(q, 8'hC3);
      do_op(1'b0, 10'h13C, 8'h00);
      expect8(q, 8'h3C);
      @(posedge clk);
      useX <= 1'b0;
   endtask : t_modes
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : complete_run
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         bad_count++;
         $display("BAD %0t timeout", $time);
         complete_run();
      end
   end
   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      expect8({4'h0, reqReady, memSelectN, memWriteN, memDataOe}, 8'h0E);
      t_walls();
      t_refused();
      t_modes();
      complete_run();
   end
endmodule : dps_port_ctrl_tb
